// file: sim/otpps_mem_model.sv
// Purpose: Four-byte OTP memory model
// Assumes: Bits only clear when programmed
// Notes: Weak byte sticks after need_in pulses
`timescale 1ns/1ps
module otpps_mem_model
  import otpps_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE = 8'h3c // Arbitrary value
) (
  input otpps_pkg::otpps_pins_t pins_in,
  input wire logic [1:0] weak_addr_in,
  input wire logic [7:0] need_in,
  input wire logic corrupt_in,
  output logic [7:0] data_pin_out,
  output int pulses_out
);
  logic [7:0] mem [4];
  logic [7:0] hits [4];
  task automatic erase();
    for (int i = 0; i < 4; i++) begin
      mem[i] = 8'hff;
      hits[i] = 8'h00;
    end
    pulses_out = 0;
  endtask : erase
  initial begin
    data_pin_out = 8'h00;
    erase();
  end
  always @(posedge pins_in.ce_n) begin
    logic [1:0] a;
    a = pins_in.addr[1:0];
    if (pins_in.vcc_sel == OTPPS_SUP_6V5 && pins_in.vpp_sel == OTPPS_SUP_13V0 && pins_in.oe_n) begin
      pulses_out = pulses_out + 1;
      hits[a] = hits[a] + 8'h01;
      if (a != weak_addr_in || hits[a] >= need_in) mem[a] = mem[a] & pins_in.data;
    end
  end
  function automatic logic [7:0] rd();
    if (pins_in.id_high_voltage) return pins_in.addr[0] ? DEVICE : MAKER;
    return mem[pins_in.addr[1:0]] ^ {8{corrupt_in && pins_in.vcc_sel == OTPPS_SUP_5V0}};
  endfunction : rd
  always @(pins_in.oe_n or pins_in.addr or pins_in.id_high_voltage) begin
    data_pin_out = ~data_pin_out; // Released lines never keep the old byte
    if (!pins_in.oe_n) data_pin_out <= #140 rd();
  end
endmodule : otpps_mem_model

// file: sim/otpps_seq_properties.sv
// Purpose: Pin timing checks
// Assumes: clk_en_in high
// Notes: Counters measure enable spans
`timescale 1ns/1ps
module otpps_seq_properties
  import otpps_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input otpps_pkg::otpps_pins_t pins_out,
  input otpps_pkg::otpps_status_t status_out
);
  logic [WAIT_W-1:0] ce_cnt;
  logic [WAIT_W-1:0] lo_cnt;
  logic [WAIT_W-1:0] hi_cnt;
  always_ff @(posedge clk_sys_in) begin
    ce_cnt <= (reset_in || pins_out.ce_n) ? '0 : ce_cnt + 1'b1;
  end
  always_ff @(posedge clk_sys_in) begin
    lo_cnt <= (reset_in || pins_out.oe_n) ? '0 : lo_cnt + 1'b1;
  end
  // Saturates so long idle spans cannot wrap
  always_ff @(posedge clk_sys_in) begin
    hi_cnt <= (reset_in || !pins_out.oe_n) ? '0 : hi_cnt + (hi_cnt != 13'h00f);
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  enables_apart_a: assert property (pins_out.ce_n || pins_out.oe_n)
    else $error("ce and oe low together");
  drive_quiet_a: assert property (!pins_out.data_oe_n |-> pins_out.oe_n)
    else $error("data driven during read");
  pulse_width_a: assert property ($rose(pins_out.ce_n) |-> ce_cnt == PULSE_CYC)
    else $error("pulse width wrong");
  pulse_supply_a: assert property (!pins_out.ce_n |->
    pins_out.vcc_sel == OTPPS_SUP_6V5 && pins_out.vpp_sel == OTPPS_SUP_13V0)
    else $error("pulse at wrong supply");
  supply_order_a: assert property (pins_out.vpp_sel != OTPPS_SUP_READ |->
    pins_out.vcc_sel != OTPPS_SUP_READ)
    else $error("vpp without vcc");
  vpp_rise_a: assert property ($changed(pins_out.vpp_sel) && pins_out.vpp_sel == OTPPS_SUP_13V0 |->
    $past(pins_out.vcc_sel) == OTPPS_SUP_6V5)
    else $error("vpp raised first");
  float_gap_a: assert property ($fell(pins_out.data_oe_n) |-> hi_cnt >= FLOAT_CYC)
    else $error("data driven too soon");
  read_wait_a: assert property ($rose(pins_out.oe_n) |-> lo_cnt >= VFY_CYC)
    else $error("read too short");
  first_addr_a: assert property ($rose(status_out.busy) |-> pins_out.addr == '0)
    else $error("run not at address zero");
  id_path_a: assert property (pins_out.id_high_voltage |-> pins_out.ce_n && pins_out.data_oe_n)
    else $error("id mode while writing");
  done_pulse_a: assert property (status_out.done |=> !status_out.done)
    else $error("done too long");
  cover property ($rose(pins_out.ce_n));
  cover property (status_out.done && status_out.pass);
  cover property (status_out.done && status_out.fail);
  cover property (pins_out.id_high_voltage);
endmodule : otpps_seq_properties

// file: sim/otpps_sequencer_test.sv
// Purpose: Self-checking bench
// Assumes: Four-byte image
// Notes: Rows cover clean, boundary retry and failing runs
`timescale 1ns/1ps
module otpps_sequencer_test;
  import otpps_pkg::*;
  typedef struct {logic [7:0] need; logic bad; logic pass; int pulses; logic [7:0] base;} otpps_row_t;
  otpps_row_t rows [3] = '{'{8'h01, 1'b0, 1'b1, 4, 8'h5a}, '{8'h0b, 1'b0, 1'b1, 14, 8'hc3},
    '{8'h01, 1'b1, 1'b0, 4, 8'h0f}};
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic start_in = 1'b0;
  logic id_read_in = 1'b0;
  logic src_valid_in = 1'b0;
  logic bad = 1'b0;
  logic [7:0] src_data_in = 8'h00;
  logic [7:0] need = 8'h01;
  logic [7:0] mem_data;
  logic [7:0] data_pin_in;
  logic [7:0] maker_code_out;
  logic [7:0] device_code_out;
  logic src_ready_out;
  otpps_pins_t pins_out;
  otpps_status_t status_out;
  int fails = 0;
  int samples_checked = 0;
  int pulses;
  always #12.5 clk_sys_in = ~clk_sys_in;
  assign data_pin_in = pins_out.data_oe_n ? mem_data : pins_out.data;
  otpps_sequencer #(.LAST_ADDR(19'h00003)) i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .start_in(start_in), .id_read_in(id_read_in), .src_data_in(src_data_in),
    .src_valid_in(src_valid_in), .src_ready_out(src_ready_out), .data_pin_in(data_pin_in),
    .pins_out(pins_out), .status_out(status_out), .maker_code_out(maker_code_out),
    .device_code_out(device_code_out));
  otpps_mem_model i_mem (.pins_in(pins_out), .weak_addr_in(2'h2), .need_in(need), .corrupt_in(bad),
    .data_pin_out(mem_data), .pulses_out(pulses));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    i_mem.erase();
  endtask : do_reset
  task automatic feed(input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      src_data_in <= base + 8'(i % 4);
      src_valid_in <= 1'b1;
      @(negedge clk_sys_in);
      while (src_ready_out !== 1'b1) @(negedge clk_sys_in);
      @(posedge clk_sys_in);
    end
    src_valid_in <= 1'b0;
  endtask : feed
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (status_out.done !== 1'b1 && n < 80000);
    check(status_out.done, 1'b1);
    @(posedge clk_sys_in);
  endtask : wait_done
  initial begin
    do_reset();
    @(negedge clk_sys_in);
    check(pins_out, PINS_RESET);
    check(status_out, 4'h0);
    @(posedge clk_sys_in);
    foreach (rows[r]) begin
      need <= rows[r].need;
      bad <= rows[r].bad;
      start_in <= 1'b1;
      @(posedge clk_sys_in);
      start_in <= 1'b0;
      fork
        feed(rows[r].base, 12);
        wait_done();
      join
      check(status_out.pass, rows[r].pass);
      check(status_out.fail, !rows[r].pass);
      check(pulses, rows[r].pulses);
      do_reset();
    end
    id_read_in <= 1'b1;
    @(posedge clk_sys_in);
    id_read_in <= 1'b0;
    // Enable low must hold the read well past its capture point
    repeat (40) @(posedge clk_sys_in);
    clk_en_in <= 1'b0;
    repeat (100) @(posedge clk_sys_in);
    clk_en_in <= 1'b1;
    check(maker_code_out, 8'h00);
    wait_done();
    check(maker_code_out, 8'h5a);
    check(device_code_out, 8'h3c);
    // Reset in mid-pulse drops every pin at once
    feed(8'h20, 4);
    start_in <= 1'b1;
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    repeat (300) @(posedge clk_sys_in);
    check(pins_out.ce_n, 1'b0);
    do_reset();
    @(negedge clk_sys_in);
    check(pins_out, PINS_RESET);
    check(status_out, 4'h0);
    @(posedge clk_sys_in);
    // Full buffer must refuse; reset flushes it
    feed(8'h00, 16);
    @(negedge clk_sys_in);
    check(src_ready_out, 1'b0);
    @(posedge clk_sys_in);
    do_reset();
    finish_test();
  end
  initial begin
    #(25 * 100000);
    fails++;
    finish_test();
  end
endmodule : otpps_sequencer_test
bind otpps_sequencer otpps_seq_properties i_props (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .pins_out(pins_out), .status_out(status_out));

// file: src/otpps_pkg.sv
// Purpose: Shared constants and types for the OTP program/verify sequencer
// Assumes: 40 MHz system clock
// Notes: Times are kept in ns; cycle counts derive from them
package otpps_pkg;
  localparam int CLK_NS = 25;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int MAX_RETRY = 10;
  localparam int WAIT_W = 13;
  // Timing figures in ns; SYNC_STAGES is a stage count
  localparam int PROG_PULSE_NS = 100000;
  localparam int SETUP_NS = 2000;
  localparam int VERIFY_DATA_DELAY_NS = 150;
  localparam int OUTPUT_FLOAT_DELAY_NS = 130;
  localparam int SYNC_STAGES = 3;
  // Nominal pulse rounds down; least times round up
  localparam logic [WAIT_W-1:0] PULSE_CYC = WAIT_W'(PROG_PULSE_NS / CLK_NS);
  localparam logic [WAIT_W-1:0] SETUP_CYC = WAIT_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [WAIT_W-1:0] VFY_CYC =
    WAIT_W'((VERIFY_DATA_DELAY_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [WAIT_W-1:0] FLOAT_CYC = WAIT_W'((OUTPUT_FLOAT_DELAY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] PASS_FIRST = 2'h0;
  localparam logic [1:0] PASS_VERIFY = 2'h1;
  localparam logic [1:0] PASS_FINAL = 2'h2;

  typedef enum logic [1:0] {
    OTPPS_SUP_READ = 2'h0,
    OTPPS_SUP_5V0 = 2'h1,
    OTPPS_SUP_6V5 = 2'h2,
    OTPPS_SUP_13V0 = 2'h3
  } otpps_supply_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic data_oe_n;
    logic ce_n;
    logic oe_n;
    logic id_high_voltage;
    otpps_supply_t vcc_sel;
    otpps_supply_t vpp_sel;
  } otpps_pins_t;

  localparam otpps_pins_t PINS_RESET = '{addr: '0, data: '0, data_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1,
    id_high_voltage: 1'b0, vcc_sel: OTPPS_SUP_READ, vpp_sel: OTPPS_SUP_READ};

  typedef struct packed {
    logic busy;
    logic done;
    logic pass;
    logic fail;
  } otpps_status_t;
endpackage : otpps_pkg

// file: src/otpps_sequencer.sv
// Purpose: Host-side programmer driving a byte-wide OTP memory through its pins
// Assumes: Source replays the image in address order once per pass (three passes)
// Notes: Supplies are requested as level selects; external switches make the volts
`timescale 1ns/1ps

module otpps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic [PTR_W:0] next_count;
  logic push;
  logic pop;

  // Ready is registered so the source sees no combinational path through us
  assign next_count = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (clk_en_in && push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      wr_ready_out <= 1'b1;
    end else if (clk_en_in) begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      wr_ready_out <= (next_count != (PTR_W+1)'(DEPTH));
    end
  end
endmodule : otpps_fifo

module otpps_sequencer
  import otpps_pkg::*;
#(
  parameter logic [otpps_pkg::ADDR_W-1:0] LAST_ADDR = '1,
  parameter int RETRY_LIMIT = otpps_pkg::MAX_RETRY
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire logic id_read_in,
  input wire logic [otpps_pkg::DATA_W-1:0] src_data_in,
  input wire logic src_valid_in,
  output logic src_ready_out,
  input wire logic [otpps_pkg::DATA_W-1:0] data_pin_in,
  output otpps_pkg::otpps_pins_t pins_out,
  output otpps_pkg::otpps_status_t status_out,
  output logic [otpps_pkg::DATA_W-1:0] maker_code_out,
  output logic [otpps_pkg::DATA_W-1:0] device_code_out
);
  import otpps_pkg::*;

  typedef enum logic [14:0] {
    S_IDLE = 15'h0001,
    S_UP_VCC = 15'h0002,
    S_UP_VPP = 15'h0004,
    S_FETCH = 15'h0008,
    S_SETUP = 15'h0010,
    S_PULSE = 15'h0020,
    S_HOLD = 15'h0040,
    S_FLOAT = 15'h0080,
    S_READ = 15'h0100,
    S_CMP = 15'h0200,
    S_DN_VPP = 15'h0400,
    S_DN_VCC = 15'h0800,
    S_OFF_VPP = 15'h1000,
    S_OFF_VCC = 15'h2000,
    S_ID = 15'h4000
  } otpps_state_t;

  otpps_state_t state;
  logic [WAIT_W-1:0] wait_cnt;
  logic [1:0] pass_no;
  logic [3:0] retry;
  logic [DATA_W-1:0] want;
  logic failed;
  logic id_second;
  logic [DATA_W-1:0] sync1;
  logic [DATA_W-1:0] sync2;
  logic [DATA_W-1:0] sync3;
  logic [DATA_W-1:0] rd_byte;
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic wait_done;
  logic last_addr;
  logic match;

  assign wait_done = (wait_cnt == '0);
  assign last_addr = (pins_out.addr == LAST_ADDR);
  assign match = (rd_byte == want);
  assign fifo_pop = (state == S_FETCH) && fifo_valid;

  otpps_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .wr_data_in(src_data_in),
    .wr_valid_in(src_valid_in),
    .wr_ready_out(src_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop)
  );

  // Pin data is asynchronous to us; accept a value once stages two and three agree
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      rd_byte <= '0;
    end else if (clk_en_in) begin
      sync1 <= data_pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        rd_byte <= sync3;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state <= S_IDLE;
      wait_cnt <= '0;
      pass_no <= PASS_FIRST;
      retry <= '0;
      want <= '0;
      failed <= 1'b0;
      id_second <= 1'b0;
      pins_out <= PINS_RESET;
      status_out <= '0;
      maker_code_out <= '0;
      device_code_out <= '0;
    end else if (clk_en_in) begin
      status_out.done <= 1'b0;
      if (!wait_done) begin
        wait_cnt <= wait_cnt - 1'b1;
      end
      unique case (state)
        S_IDLE: begin
          if (start_in) begin
            pins_out.addr <= '0;
            pins_out.vcc_sel <= OTPPS_SUP_6V5;
            wait_cnt <= SETUP_CYC;
            pass_no <= PASS_FIRST;
            failed <= 1'b0;
            status_out <= '{busy: 1'b1, done: 1'b0, pass: 1'b0, fail: 1'b0};
            state <= S_UP_VCC;
          end else if (id_read_in) begin
            pins_out.addr <= '0;
            pins_out.id_high_voltage <= 1'b1;
            pins_out.oe_n <= 1'b0;
            id_second <= 1'b0;
            wait_cnt <= SETUP_CYC;
            status_out.busy <= 1'b1;
            state <= S_ID;
          end
        end
        S_UP_VCC: begin
          if (wait_done) begin
            pins_out.vpp_sel <= OTPPS_SUP_13V0;
            wait_cnt <= SETUP_CYC;
            state <= S_UP_VPP;
          end
        end
        S_UP_VPP: begin
          if (wait_done) begin
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (fifo_valid) begin
            want <= fifo_data;
            retry <= '0;
            if (pass_no == PASS_FIRST) begin
              pins_out.data <= fifo_data;
              pins_out.data_oe_n <= 1'b0;
              wait_cnt <= SETUP_CYC;
              state <= S_SETUP;
            end else begin
              pins_out.oe_n <= 1'b0;
              wait_cnt <= VFY_CYC;
              state <= S_READ;
            end
          end
        end
        S_SETUP: begin
          if (wait_done) begin
            pins_out.ce_n <= 1'b0;
            wait_cnt <= PULSE_CYC - 1'b1;
            state <= S_PULSE;
          end
        end
        S_PULSE: begin
          // Output enable is held high here, so the part never drives against us
          if (wait_done) begin
            pins_out.ce_n <= 1'b1;
            wait_cnt <= SETUP_CYC;
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (wait_done) begin
            pins_out.data_oe_n <= 1'b1;
            if (pass_no == PASS_FIRST) begin
              // One pulse only, no read back
              if (last_addr) begin
                pins_out.addr <= '0;
                pass_no <= PASS_VERIFY;
              end else begin
                pins_out.addr <= pins_out.addr + 1'b1;
              end
              state <= S_FETCH;
            end else begin
              pins_out.oe_n <= 1'b0;
              wait_cnt <= VFY_CYC;
              state <= S_READ;
            end
          end
        end
        S_READ: begin
          if (wait_done) begin
            state <= S_CMP;
          end
        end
        S_CMP: begin
          pins_out.oe_n <= 1'b1;
          wait_cnt <= FLOAT_CYC;
          if (match) begin
            if (last_addr) begin
              state <= (pass_no == PASS_VERIFY) ? S_DN_VPP : S_OFF_VPP;
            end else begin
              pins_out.addr <= pins_out.addr + 1'b1;
              state <= S_FETCH;
            end
          end else if (pass_no == PASS_FINAL) begin
            failed <= 1'b1;
            state <= S_OFF_VPP;
          end else if (retry == 4'(RETRY_LIMIT)) begin
            failed <= 1'b1;
            state <= S_OFF_VPP;
          end else begin
            retry <= retry + 1'b1;
            state <= S_FLOAT;
          end
        end
        S_FLOAT: begin
          // The part may still drive the bus for the float delay after release
          if (wait_done) begin
            pins_out.data <= want;
            pins_out.data_oe_n <= 1'b0;
            wait_cnt <= SETUP_CYC;
            state <= S_SETUP;
          end
        end
        S_DN_VPP: begin
          if (wait_done) begin
            pins_out.vpp_sel <= OTPPS_SUP_5V0;
            wait_cnt <= SETUP_CYC;
            state <= S_DN_VCC;
          end
        end
        S_DN_VCC: begin
          if (wait_done) begin
            pins_out.vcc_sel <= OTPPS_SUP_5V0;
            pins_out.addr <= '0;
            pass_no <= PASS_FINAL;
            wait_cnt <= SETUP_CYC;
            state <= S_UP_VPP;
          end
        end
        S_OFF_VPP: begin
          if (wait_done) begin
            pins_out.vpp_sel <= OTPPS_SUP_READ;
            wait_cnt <= SETUP_CYC;
            state <= S_OFF_VCC;
          end
        end
        S_OFF_VCC: begin
          if (wait_done) begin
            pins_out.vcc_sel <= OTPPS_SUP_READ;
            status_out <= '{busy: 1'b0, done: 1'b1, pass: !failed, fail: failed};
            state <= S_IDLE;
          end
        end
        S_ID: begin
          if (wait_done) begin
            if (!id_second) begin
              maker_code_out <= rd_byte;
              pins_out.addr <= ADDR_W'(1);
              id_second <= 1'b1;
              wait_cnt <= SETUP_CYC;
            end else begin
              device_code_out <= rd_byte;
              pins_out.oe_n <= 1'b1;
              pins_out.id_high_voltage <= 1'b0;
              pins_out.addr <= '0;
              status_out.busy <= 1'b0;
              status_out.done <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule : otpps_sequencer
